// *** logic/ees_fifo.sv ***
`timescale 1ns/10ps
module ees_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	// Clock and reset
	input  wire logic             mclk,
	input  wire logic             sys_rst,
	// Fill side
	input  wire logic             in_valid,
	output      logic             in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// Drain side
	output      logic             out_valid,
	input  wire logic             out_ready,
	output      logic [WIDTH-1:0] out_data
);

	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] buf_mem [DEPTH];
	logic [AW-1:0]    wr_ptr_reg;
	logic [AW-1:0]    rd_ptr_reg;
	logic [AW:0]      count_reg;
	logic             push;
	logic             pop;

	assign in_ready  = (count_reg != (AW+1)'(DEPTH));
	assign out_valid = (count_reg != '0);
	assign out_data  = buf_mem[rd_ptr_reg];
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;

	always_ff @(posedge mclk) begin
		if (push) begin
			buf_mem[wr_ptr_reg] <= in_data;
		end
	end

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg  <= '0;
		end else begin
			if (push) begin
				wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0
					: wr_ptr_reg + 1'b1;
			end
			if (pop) begin
				rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0
					: rd_ptr_reg + 1'b1;
			end
			count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
		end
	end

endmodule

// *** logic/ees_front_end.sv ***
`timescale 1ns/10ps
// Functional notes
// - Main array holds 8192 bytes, reached only over the serial pins.
// - A separate 32-byte identification page exists beside the main array.
// - Identification page can be locked for good; afterwards reads only. The lock flag clears on sys_rst.
// - Device is selected only while chip select is held low.
// - Serial output bits change on falling serial clock edges.
// - Input bits are captured on rising serial clock edges.
// - With chip select high, device is deselected and output floats.
// - Deselected device drops to standby unless a write cycle still runs.
// - Chip select low puts the device into active power.
// - After power-up nothing is accepted before a chip select falling edge.
// - Pause input low suspends transfer, keeping selection and bit position.
// - While paused, output floats and clock and data input are ignored.
// - Pause is entered only while selected; master keeps chip select low.
// - Write-protect low with SRWD set freezes the protected-size bits against change.
// - All bytes travel most significant bit first, both directions.
// - Pause starts and ends only while the serial clock is low.
// - Deselecting during pause resets protocol; latch and busy flags stay.
module ees_front_end
	import ees_pkg::*;
#(
	parameter int WRITE_CYCLES = WRITE_CYC
) (
	// Clock and reset
	input  wire logic mclk,
	input  wire logic sys_rst,
	// Serial pins from the bus master
	input  wire logic sck,
	input  wire logic cs_n,
	input  wire logic si,
	input  wire logic hold_n,
	input  wire logic wp_n,
	// Serial data output pin
	output      logic so_out,
	output      logic so_oe,
	// Power state
	output      logic active_pwr
);

	ees_pins_s         pins_s;
	logic [7:0]        mem [ARRAY_BYTES];
	logic [7:0]        id_mem [ID_BYTES];

	logic              sck_prev_reg;
	logic              cs_prev_reg;
	logic              armed_reg;
	logic              sel_reg;
	logic              hold_reg;
	ees_phase_e        phase_reg;
	logic [7:0]        op_reg;
	logic [6:0]        sh_reg;
	logic [2:0]        bit_cnt_reg;
	logic [ADDR_W-1:0] addr_reg;
	logic [7:0]        out_byte_reg;
	logic              data_seen_reg;
	logic [7:0]        sr_new_reg;
	logic              write_enable_latch;
	logic              write_in_progress;
	logic              protect_range_bit_hi;
	logic              protect_range_bit_lo;
	logic              srwd_reg;
	logic              id_locked_reg;
	logic              drain_reg;
	logic              commit_reg;
	logic [31:0]       wcnt_reg;
	logic              so_reg;
	logic              so_oe_reg;
	logic              active_pwr_reg;

	logic              selected;
	logic              end_frame;
	logic              rise;
	logic              fall;
	logic              byte_done;
	logic [7:0]        in_byte;
	logic [7:0]        status_byte;
	ees_phase_e        cmd_next;
	logic              is_wr_op;
	logic              is_id_op;
	logic [ADDR_W-1:0] rd_addr;
	logic [ADDR_W-1:0] addr_inc;
	logic [7:0]        rd_data;
	logic              wr_ok;
	logic              sr_ok;
	logic              push;
	logic              fifo_in_ready;
	logic              fifo_out_valid;
	ees_wr_s           fifo_out;
	ees_wr_s           fifo_in;
	logic              mem_allowed;

	// Every pin crosses into mclk through two flops
	ees_sync #(
		.W (5)
	) u_sync (
		.mclk     (mclk),
		.sys_rst  (sys_rst),
		.in_async ({sck, cs_n, si, hold_n, wp_n}),
		.out_sync (pins_s)
	);

	// arm on CS fall
	// Reset value 0 means a chip select held low from power-up never arms
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			cs_prev_reg <= 1'b0;
			armed_reg   <= 1'b0;
		end else begin
			cs_prev_reg <= pins_s.cs_n;
			if (cs_prev_reg && !pins_s.cs_n) begin
				armed_reg <= 1'b1;
			end
		end
	end

	assign selected  = armed_reg & ~pins_s.cs_n;
	assign end_frame = sel_reg & ~selected;

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			sel_reg      <= 1'b0;
			sck_prev_reg <= 1'b0;
		end else begin
			sel_reg      <= selected;
			sck_prev_reg <= pins_s.sck;
		end
	end

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			hold_reg <= 1'b0;
		end else if (!selected) begin
			hold_reg <= 1'b0;
		end else if (!pins_s.sck) begin
			hold_reg <= ~pins_s.hold_n;
		end
	end

	assign rise      = selected & ~hold_reg & pins_s.sck & ~sck_prev_reg;
	assign fall      = selected & ~hold_reg & ~pins_s.sck & sck_prev_reg;
	assign byte_done = rise & (bit_cnt_reg == 3'h7);
	assign in_byte   = {sh_reg, pins_s.si};

	assign status_byte = {srwd_reg, 3'h0, protect_range_bit_hi,
		protect_range_bit_lo, write_enable_latch, write_in_progress};
	assign is_wr_op = (op_reg == OP_WRITE) | (op_reg == OP_WRID);
	assign is_id_op = (op_reg == OP_RDID) | (op_reg == OP_WRID);

	// Busy device answers status reads only
	always_comb begin
		cmd_next = PH_IGN;
		if (!write_in_progress || in_byte == OP_RDSR) begin
			unique case (in_byte)
				OP_RDSR:           cmd_next = PH_DOUT;
				OP_READ, OP_RDID:  cmd_next = PH_AHI;
				OP_WRITE, OP_WRID: cmd_next = write_enable_latch ? PH_AHI
					: PH_IGN;
				OP_WRSR:           cmd_next = write_enable_latch ? PH_DIN
					: PH_IGN;
				default:           cmd_next = PH_IGN;
			endcase
		end
	end

	always_comb begin
		rd_addr = (phase_reg == PH_ALO) ? {addr_reg[ADDR_W-1:8], in_byte}
			: addr_reg;
		if (op_reg == OP_RDSR) begin
			rd_data = status_byte;
		end else if (op_reg == OP_RDID && rd_addr[LOCK_SEL]) begin
			rd_data = {7'h00, id_locked_reg};
		end else if (op_reg == OP_RDID) begin
			rd_data = id_mem[rd_addr[ID_AW-1:0]];
		end else begin
			rd_data = mem[rd_addr];
		end
	end

	// Writes and page reads wrap within one page; array reads run on
	always_comb begin
		addr_inc = rd_addr + 13'h0001;
		if (is_id_op || phase_reg == PH_DIN) begin
			addr_inc = {rd_addr[ADDR_W-1:PAGE_AW],
				rd_addr[PAGE_AW-1:0] + 5'h01};
		end
	end

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			phase_reg     <= PH_CMD;
			op_reg        <= 8'h00;
			sh_reg        <= 7'h00;
			bit_cnt_reg   <= 3'h0;
			addr_reg      <= '0;
			out_byte_reg  <= 8'h00;
			data_seen_reg <= 1'b0;
			sr_new_reg    <= 8'h00;
		end else if (!selected) begin
			phase_reg     <= PH_CMD;
			bit_cnt_reg   <= 3'h0;
			data_seen_reg <= 1'b0;
		end else if (rise) begin
			sh_reg      <= in_byte[6:0];
			bit_cnt_reg <= bit_cnt_reg + 3'h1;
			if (byte_done) begin
				unique case (phase_reg)
					PH_CMD: begin
						op_reg    <= in_byte;
						phase_reg <= cmd_next;
						out_byte_reg <= status_byte;
					end
					PH_AHI: begin
						addr_reg[ADDR_W-1:8] <= in_byte[ADDR_W-9:0];
						phase_reg <= PH_ALO;
					end
					PH_ALO: begin
						addr_reg  <= is_wr_op ? rd_addr : addr_inc;
						phase_reg <= is_wr_op ? PH_DIN : PH_DOUT;
						out_byte_reg <= rd_data;
					end
					PH_DIN: begin
						data_seen_reg <= 1'b1;
						sr_new_reg    <= in_byte;
						addr_reg      <= addr_inc;
					end
					PH_DOUT: begin
						out_byte_reg <= rd_data;
						addr_reg     <= addr_inc;
					end
					PH_IGN: begin
						phase_reg <= PH_IGN;
					end
				endcase
			end
		end
	end

	// Bytes beyond the buffer depth are dropped while it is full
	assign push = byte_done & (phase_reg == PH_DIN) & is_wr_op & ~drain_reg;
	assign fifo_in.to_id = is_id_op;
	assign fifo_in.addr  = addr_reg;
	assign fifo_in.data  = in_byte;

	ees_fifo #(
		.WIDTH ($bits(ees_wr_s)),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.mclk      (mclk),
		.sys_rst   (sys_rst),
		.in_valid  (push),
		.in_ready  (fifo_in_ready),
		.in_data   (fifo_in),
		.out_valid (fifo_out_valid),
		.out_ready (drain_reg),
		.out_data  (fifo_out)
	);

	// Only whole bytes launch a write at deselect
	assign wr_ok = end_frame & is_wr_op & (phase_reg == PH_DIN)
		& data_seen_reg & (bit_cnt_reg == 3'h0);
	assign sr_ok = end_frame & (op_reg == OP_WRSR) & (phase_reg == PH_DIN)
		& data_seen_reg & (bit_cnt_reg == 3'h0) & ~(srwd_reg & ~pins_s.wp_n);

	// Protected region is the top quarter, half or whole array
	always_comb begin
		unique case ({protect_range_bit_hi, protect_range_bit_lo})
			2'h0: mem_allowed = 1'b1;
			2'h1: mem_allowed = (fifo_out.addr[ADDR_W-1:ADDR_W-2] != 2'h3);
			2'h2: mem_allowed = ~fifo_out.addr[ADDR_W-1];
			2'h3: mem_allowed = 1'b0;
		endcase
	end

	// Drain after each frame; aborted writes are flushed unused
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			drain_reg  <= 1'b0;
			commit_reg <= 1'b0;
		end else if (end_frame) begin
			drain_reg  <= 1'b1;
			commit_reg <= wr_ok;
		end else if (drain_reg && !fifo_out_valid) begin
			drain_reg  <= 1'b0;
			commit_reg <= 1'b0;
		end
	end

	always_ff @(posedge mclk) begin
		if (drain_reg && commit_reg && fifo_out_valid && !fifo_out.to_id
			&& mem_allowed) begin
			mem[fifo_out.addr] <= fifo_out.data;
		end
	end

	always_ff @(posedge mclk) begin
		if (drain_reg && commit_reg && fifo_out_valid && fifo_out.to_id
			&& !fifo_out.addr[LOCK_SEL] && !id_locked_reg) begin
			id_mem[fifo_out.addr[ID_AW-1:0]] <= fifo_out.data;
		end
	end

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			id_locked_reg <= 1'b0;
		end else if (drain_reg && commit_reg && fifo_out_valid
			&& fifo_out.to_id && fifo_out.addr[LOCK_SEL]) begin
			id_locked_reg <= 1'b1;
		end
	end

	// Status bits; latch and busy survive any deselect
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			write_enable_latch   <= 1'b0;
			protect_range_bit_hi <= BP_RESET[1];
			protect_range_bit_lo <= BP_RESET[0];
			srwd_reg             <= SRWD_RESET;
		end else begin
			if (byte_done && phase_reg == PH_CMD && !write_in_progress) begin
				if (in_byte == OP_WREN) begin
					write_enable_latch <= 1'b1;
				end else if (in_byte == OP_WRDI) begin
					write_enable_latch <= 1'b0;
				end
			end
			if (sr_ok) begin
				srwd_reg             <= sr_new_reg[SR_SRWD];
				protect_range_bit_hi <= sr_new_reg[SR_BP_HI];
				protect_range_bit_lo <= sr_new_reg[SR_BP_LO];
			end
			if (write_in_progress && !drain_reg
				&& wcnt_reg == 32'(WRITE_CYCLES - 1)) begin
				write_enable_latch <= 1'b0;
			end
		end
	end

	// Write cycle timer starts once the buffer has drained
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			write_in_progress <= 1'b0;
			wcnt_reg          <= 32'h0;
		end else if (wr_ok || sr_ok) begin
			write_in_progress <= 1'b1;
			wcnt_reg          <= 32'h0;
		end else if (write_in_progress && !drain_reg) begin
			if (wcnt_reg == 32'(WRITE_CYCLES - 1)) begin
				write_in_progress <= 1'b0;
			end else begin
				wcnt_reg <= wcnt_reg + 32'h1;
			end
		end
	end

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			so_reg <= 1'b0;
		end else if (fall && phase_reg == PH_DOUT) begin
			so_reg <= out_byte_reg[3'h7 - bit_cnt_reg];
		end
	end

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			so_oe_reg <= 1'b0;
		end else begin
			so_oe_reg <= selected & ~hold_reg & (phase_reg == PH_DOUT);
		end
	end

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			active_pwr_reg <= 1'b0;
		end else begin
			active_pwr_reg <= selected | write_in_progress;
		end
	end

	assign so_out     = so_reg;
	assign so_oe      = so_oe_reg;
	assign active_pwr = active_pwr_reg;

endmodule

// *** logic/ees_sync.sv ***
`timescale 1ns/10ps
module ees_sync #(
	parameter int W = 1
) (
	// Clock and reset
	input  wire logic         mclk,
	input  wire logic         sys_rst,
	// Levels
	input  wire logic [W-1:0] in_async,
	output      logic [W-1:0] out_sync
);

	logic [W-1:0] meta_reg;

	// One two-stage chain per bit
	for (genvar i = 0; i < W; i++) begin : g_bit
		always_ff @(posedge mclk or posedge sys_rst) begin
			// Low after reset, so a select held low shows no false fall
			if (sys_rst) begin
				meta_reg[i] <= 1'b0;
				out_sync[i] <= 1'b0;
			end else begin
				meta_reg[i] <= in_async[i];
				out_sync[i] <= meta_reg[i];
			end
		end
	end

endmodule

// *** shared/ees_pkg.sv ***
package ees_pkg;

	// Array geometry
	localparam int ARRAY_BYTES = 8192;
	localparam int ADDR_W      = 13;
	localparam int ID_BYTES    = 32;
	localparam int ID_AW       = 5;
	localparam int PAGE_AW     = 5;
	localparam int LOCK_SEL    = 10;

	// Write path buffer
	localparam int FIFO_DEPTH  = 16;

	// Internal write cycle length in mclk cycles
	localparam int WRITE_CYC   = 1024;

	// Instruction codes
	localparam logic [7:0] OP_WRSR  = 8'h01;
	localparam logic [7:0] OP_WRITE = 8'h02;
	localparam logic [7:0] OP_READ  = 8'h03;
	localparam logic [7:0] OP_WRDI  = 8'h04;
	localparam logic [7:0] OP_RDSR  = 8'h05;
	localparam logic [7:0] OP_WREN  = 8'h06;
	localparam logic [7:0] OP_WRID  = 8'h82;
	localparam logic [7:0] OP_RDID  = 8'h83;

	// Status byte layout and reset values
	localparam int SR_SRWD  = 7;
	localparam int SR_BP_HI = 3;
	localparam int SR_BP_LO = 2;
	localparam int SR_WEL   = 1;
	localparam int SR_WIP   = 0;
	localparam logic [1:0] BP_RESET   = 2'h0;
	localparam logic       SRWD_RESET = 1'b0;

	// Protocol phase within one selection
	typedef enum logic [5:0] {
		PH_CMD  = 6'b000001,
		PH_AHI  = 6'b000010,
		PH_ALO  = 6'b000100,
		PH_DIN  = 6'b001000,
		PH_DOUT = 6'b010000,
		PH_IGN  = 6'b100000
	} ees_phase_e;

	// One buffered write byte
	typedef struct packed {
		logic              to_id;
		logic [ADDR_W-1:0] addr;
		logic [7:0]        data;
	} ees_wr_s;

	// Serial pins as one bundle
	typedef struct packed {
		logic sck;
		logic cs_n;
		logic si;
		logic hold_n;
		logic wp_n;
	} ees_pins_s;

endpackage

// *** testbench/ees_front_end_sva.sv ***
`timescale 1ns/10ps
module ees_front_end_chk
	import ees_pkg::*;
#(
	parameter int WRITE_CYCLES = WRITE_CYC
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic sys_rst,
	// Serial pins
	input wire logic sck,
	input wire logic cs_n,
	input wire logic si,
	input wire logic hold_n,
	input wire logic wp_n,
	// Outputs
	input wire logic so_out,
	input wire logic so_oe,
	input wire logic active_pwr
);
	logic armed_reg;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (sys_rst);

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			armed_reg <= 1'b0;
		end else if (cs_n) begin
			armed_reg <= 1'b1;
		end
	end

	sequence s_paused;
		(!cs_n && !hold_n && !sck) [*5];
	endsequence
	sequence s_selected;
		(armed_reg && !cs_n) [*6];
	endsequence

	a_cs_float:
		assert property (cs_n [*5] |-> !so_oe)
		else $error("so driven while deselected");
	a_cs_oe_drop:
		assert property ($rose(cs_n) |-> ##4 !so_oe)
		else $error("so enable late after deselect");
	a_hold_float:
		assert property (s_paused |-> !so_oe)
		else $error("so driven while paused");
	a_sel_active:
		assert property (s_selected |-> active_pwr)
		else $error("selected but in standby");
	a_standby_cs:
		assert property ($fell(active_pwr) |-> cs_n)
		else $error("standby while selected");
	a_oe_qual:
		assert property ($rose(so_oe) |-> !cs_n && hold_n)
		else $error("so enabled outside selection");
	a_so_fall_edge:
		assert property (so_oe && $past(so_oe) && $changed(so_out)
			|-> !$past(sck, 2))
		else $error("so changed away from clock fall");
	a_unarmed_quiet:
		assert property (!armed_reg |-> !so_oe && !active_pwr)
		else $error("active before first select edge");
endmodule

bind ees_front_end ees_front_end_chk #(
	.WRITE_CYCLES(WRITE_CYCLES)
) u_chk (
	.mclk(mclk), .sys_rst(sys_rst), .sck(sck), .cs_n(cs_n), .si(si),
	.hold_n(hold_n), .wp_n(wp_n), .so_out(so_out), .so_oe(so_oe),
	.active_pwr(active_pwr)
);

// *** testbench/ees_spi_master.sv ***
`timescale 1ns/10ps
module ees_spi_master (
	// Clock and read-back
	input  wire logic mclk,
	input  wire logic so_out,
	input  wire logic so_oe,
	// Serial pins
	output      logic sck,
	output      logic cs_n,
	output      logic si,
	output      logic hold_n,
	output      logic wp_n
);
	// Select low at power-up to show the unarmed case
	initial begin
		sck = 1'b0;
		cs_n = 1'b0;
		si = 1'b0;
		hold_n = 1'b1;
		wp_n = 1'b1;
	end
	task automatic tick(input int n);
		repeat (n) @(negedge mclk);
	endtask
	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--) begin
			si = tx[i];
			tick(20);
			rx[i] = so_oe ? so_out : 1'bx;
			sck = ~sck;
			tick(20);
			sck = ~sck;
		end
		// Idle data line toggles, no stale level
		si = ~si;
	endtask
	task automatic sel();
		tick(10);
		cs_n = 1'b1;
		tick(10);
		cs_n = 1'b0;
		tick(10);
	endtask
	task automatic desel();
		tick(10);
		cs_n = 1'b1;
		tick(10);
	endtask
	task automatic pause(input logic on);
		hold_n = ~on;
		tick(10);
	endtask
	// protect level changed between frames only
	task automatic set_wp(input logic v);
		wp_n = v;
		tick(5);
	endtask
endmodule

// *** testbench/tb_spi_eeprom_serial_front_end.sv ***
`timescale 1ns/10ps
module tb_spi_eeprom_serial_front_end import ees_pkg::*;;
	localparam int WR_CYC = 1024;
	logic       mclk, sys_rst, sck, cs_n, si, hold_n, wp_n;
	logic       so_out, so_oe, active_pwr;
	logic [7:0] rx;
	int         err_total = 0;
	int         checked = 0;
	int         cyc = 0;

	ees_front_end #(.WRITE_CYCLES(WR_CYC)) u_dut (
		.mclk(mclk), .sys_rst(sys_rst), .sck(sck), .cs_n(cs_n), .si(si),
		.hold_n(hold_n), .wp_n(wp_n), .so_out(so_out), .so_oe(so_oe),
		.active_pwr(active_pwr)
	);
	ees_spi_master u_mst (
		.mclk(mclk), .so_out(so_out), .so_oe(so_oe), .sck(sck),
		.cs_n(cs_n), .si(si), .hold_n(hold_n), .wp_n(wp_n)
	);

	initial begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			err_total++;
			$display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic test_done();
		$display("checks %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task automatic op1(input logic [7:0] op);
		u_mst.sel();
		u_mst.xfer(op, rx);
		u_mst.desel();
	endtask
	task automatic rd_sr(input logic [7:0] exp, input logic [7:0] mask);
		u_mst.sel();
		u_mst.xfer(OP_RDSR, rx);
		check({7'h00, so_oe}, 8'h01);
		u_mst.xfer(8'h00, rx);
		check(rx & mask, exp);
		u_mst.desel();
		check({7'h00, so_oe}, 8'h00);
	endtask
	// Bounded wait for the write cycle to end
	task automatic wait_idle();
		int n;
		n = 0;
		while (active_pwr !== 1'b0 && n < 4000) begin
			u_mst.tick(1);
			n++;
		end
		check({7'h00, active_pwr}, 8'h00);
	endtask
	task automatic wrsr(input logic [7:0] v);
		op1(OP_WREN);
		u_mst.sel();
		u_mst.xfer(OP_WRSR, rx);
		u_mst.xfer(v, rx);
		u_mst.desel();
		wait_idle();
	endtask
	// Two data bytes from low address 0x00, then wait out the write cycle
	task automatic wr2(input logic [7:0] op, input logic [7:0] ahi,
		input logic [7:0] d0, input logic [7:0] d1);
		op1(OP_WREN);
		u_mst.sel();
		u_mst.xfer(op, rx);
		u_mst.xfer(ahi, rx);
		u_mst.xfer(8'h00, rx);
		u_mst.xfer(d0, rx);
		u_mst.xfer(d1, rx);
		u_mst.desel();
		wait_idle();
	endtask
	task automatic rd2(input logic [7:0] op, input logic [7:0] ahi,
		output logic [7:0] b0, output logic [7:0] b1);
		u_mst.sel();
		u_mst.xfer(op, rx);
		u_mst.xfer(ahi, rx);
		u_mst.xfer(8'h00, rx);
		u_mst.xfer(8'h00, b0);
		u_mst.xfer(8'h00, b1);
		u_mst.desel();
	endtask

	task automatic t_unarmed();
		u_mst.xfer(OP_WREN, rx);
		check({7'h00, active_pwr}, 8'h00);
		u_mst.desel();
		rd_sr(8'h00, 8'hFF);
		$display("test unarmed done");
	endtask
	task automatic t_status();
		op1(OP_WREN);
		rd_sr(8'h02, 8'hFF);
		op1(OP_WRDI);
		rd_sr(8'h00, 8'hFF);
		$display("test status done");
	endtask
	// One past the buffer depth, last byte dropped
	task automatic t_fifo();
		op1(OP_WREN);
		u_mst.sel();
		u_mst.xfer(OP_WRITE, rx);
		u_mst.xfer(8'h00, rx);
		u_mst.xfer(8'h40, rx);
		for (int i = 0; i <= FIFO_DEPTH; i++) begin
			u_mst.xfer(8'h30 + 8'(i), rx);
		end
		u_mst.desel();
		check({7'h00, active_pwr}, 8'h01);
		rd_sr(8'h03, 8'h03);
		wait_idle();
		rd_sr(8'h00, 8'h03);
		u_mst.sel();
		u_mst.xfer(OP_READ, rx);
		u_mst.xfer(8'h00, rx);
		u_mst.xfer(8'h40, rx);
		for (int i = 0; i < FIFO_DEPTH; i++) begin
			u_mst.xfer(8'h00, rx);
			check(rx, 8'h30 + 8'(i));
		end
		u_mst.desel();
		$display("test fifo done");
	endtask
	task automatic t_hold();
		op1(OP_WREN);
		u_mst.sel();
		u_mst.xfer(OP_READ, rx);
		u_mst.xfer(8'h00, rx);
		u_mst.xfer(8'h40, rx);
		u_mst.xfer(8'h00, rx);
		check(rx, 8'h30);
		u_mst.pause(1'b1);
		check({7'h00, so_oe}, 8'h00);
		// Clock pulses while paused must not advance
		u_mst.xfer(8'hFF, rx);
		check({7'h00, active_pwr}, 8'h01);
		u_mst.pause(1'b0);
		u_mst.xfer(8'h00, rx);
		check(rx, 8'h31);
		u_mst.pause(1'b1);
		u_mst.desel();
		u_mst.pause(1'b0);
		rd_sr(8'h02, 8'hFF);
		op1(OP_WRDI);
		$display("test hold done");
	endtask
	// Page stands beside the array; lock is one-way
	task automatic t_id();
		logic [7:0] b0, b1;
		wr2(OP_WRITE, 8'h00, 8'h11, 8'h22);
		wr2(OP_WRID, 8'h00, 8'hA5, 8'h5A);
		rd2(OP_READ, 8'h00, b0, b1);
		check(b0, 8'h11);
		check(b1, 8'h22);
		rd2(OP_RDID, 8'h00, b0, b1);
		check(b0, 8'hA5);
		check(b1, 8'h5A);
		rd2(OP_RDID, 8'h04, b0, b1);
		check(b0, 8'h00);
		wr2(OP_WRID, 8'h04, 8'h01, 8'h01);
		rd2(OP_RDID, 8'h04, b0, b1);
		check(b1, 8'h01);
		wr2(OP_WRID, 8'h00, 8'hC3, 8'h3C);
		rd2(OP_RDID, 8'h00, b0, b1);
		check(b0, 8'hA5);
		check(b1, 8'h5A);
		$display("test id page done");
	endtask
	task automatic t_wp();
		logic [7:0] b0, b1;
		wrsr(8'h8C);
		rd_sr(8'h8C, 8'h8C);
		wr2(OP_WRITE, 8'h00, 8'hEE, 8'hEE);
		rd2(OP_READ, 8'h00, b0, b1);
		check(b0, 8'h11);
		check(b1, 8'h22);
		u_mst.set_wp(1'b0);
		wrsr(8'h00);
		rd_sr(8'h8C, 8'h8C);
		u_mst.set_wp(1'b1);
		wrsr(8'h00);
		rd_sr(8'h00, 8'h8C);
		$display("test protect done");
	endtask

	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 90000) begin
			err_total++;
			test_done();
		end
	end

	initial begin
		sys_rst = 1'b1;
		repeat (2) @(posedge mclk);
		@(negedge mclk);
		sys_rst = 1'b0;
		t_unarmed();
		t_status();
		t_fifo();
		t_hold();
		t_id();
		t_wp();
		test_done();
	end
endmodule
